/* core/usb_power_clock_dma_ctrl.sv */
// Overview of operation
// - Snooze request bit enters or leaves snooze.
// - Snooze bit drives internal snooze signal directly.
// - Clock select: 1 oscillator, 0 PLL.
// - PLL enable runs twelve-to-48 MHz multiplier.
// - No USB clock until reset released.
// - Bus-power bit opens controller communication.
// - Without bus power, USB reads return zero, except the misc control register.
// - Reset release bit, zero holds core reset.
// - Logic regulator enable switches 1.8 V regulator.
// - Logic regulator also starts selected oscillator.
// - PHY regulator enable switches 3.3 V regulator.
// - Write DMA enables request on free space.
// - Read DMA enables request on valid data.
// - Unimplemented DMA channel enables do nothing.
// - Bus wait bit: three or one cycles.
`include "usb_misc_consts.svh"
`default_nettype none
module usb_power_clock_dma_ctrl #(
	parameter int DMA_CHANNELS = 16
) (
	// Clock and reset
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	// Wishbone slave
	input  wire logic                      cyc_i,
	input  wire logic                      stb_i,
	input  wire logic                      we_i,
	input  wire logic [3:0]                adr_i,
	input  wire logic [3:0]                sel_i,
	input  wire logic [31:0]               dat_i,
	output logic      [31:0]               dat_o,
	output logic                           ack_o,
	// Bus-power monitor pin and FIFO levels
	input  wire logic                      bus_power_monitor_port_i,
	input  wire logic [6:0]                fifo_free_space_count_i,
	input  wire logic [6:0]                fifo_valid_data_count_i,
	// USB core controls and DMA requests
	output usb_misc_pkg::power_ctrl_s      power_ctrl_o,
	output usb_misc_pkg::dma_req_s         dma_req_o
);
	import usb_misc_pkg::*;

	logic [15:0] misc_reg;
	logic [15:0] wr_en_reg;
	logic [15:0] rd_en_reg;
	logic [2:0]  mon_sync_reg;
	logic        mon_level_reg;
	bus_state_e  state_reg;
	logic [1:0]  wait_cnt_reg;
	logic [31:0] rdata_reg;

	// Pin synchroniser: the level changes only when stages two and three agree.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mon_sync_reg  <= 3'h0;
			mon_level_reg <= 1'b0;
		end else begin
			mon_sync_reg <= {mon_sync_reg[1:0], bus_power_monitor_port_i};
			if (mon_sync_reg[1] == mon_sync_reg[2]) begin
				mon_level_reg <= mon_sync_reg[2];
			end
		end
	end

	wire bus_req    = cyc_i & stb_i;
	wire hit_misc   = adr_i == `OFS_MISC_CTRL;
	wire hit_wr     = adr_i == `OFS_WR_DMA_EN;
	wire hit_rd     = adr_i == `OFS_RD_DMA_EN;
	wire hit_status = adr_i == `OFS_USB_STATUS;
	wire bus_power  = misc_reg[`BIT_BUS_PWR_DET];

	// Access length follows the wait bit; the long setting adds wait states.
	wire [1:0] access_len = misc_reg[`BIT_BUS_WAIT] ? `WAIT_LONG_CYCLES
	                                                : `WAIT_SHORT_CYCLES;
	// A write lands at the edge where the master samples ack high, not one edge earlier.
	wire       do_write   = ack_o & bus_req & we_i;

	wire [15:0] lane_mask = {{8{sel_i[1]}}, {8{sel_i[0]}}};
	wire [15:0] misc_wmask = lane_mask & `MISC_CTRL_WMASK;

	// Other USB registers are masked to zero while bus power is absent.
	wire [15:0] rd_misc   = misc_reg;
	wire [15:0] rd_wr     = bus_power ? wr_en_reg : 16'h0000;
	wire [15:0] rd_rd     = bus_power ? rd_en_reg : 16'h0000;
	wire [15:0] rd_status = bus_power ? {15'h0000, mon_level_reg} : 16'h0000;
	wire [15:0] rd_word   = hit_misc ? rd_misc :
	                        hit_wr ? rd_wr :
	                        hit_rd ? rd_rd :
	                        hit_status ? rd_status : 16'h0000;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg    <= WAIT_IDLE;
			wait_cnt_reg <= 2'h0;
			ack_o        <= 1'b0;
			rdata_reg    <= 32'h0000_0000;
		end else begin
			unique case (state_reg)
				WAIT_IDLE: begin
					ack_o <= 1'b0;
					if (bus_req & ~ack_o) begin
						wait_cnt_reg <= access_len - 2'h1;
						state_reg    <= (access_len == 2'h1) ? WAIT_ACK : WAIT_COUNT;
					end
				end
				WAIT_COUNT: begin
					wait_cnt_reg <= wait_cnt_reg - 2'h1;
					if (wait_cnt_reg == 2'h1) begin
						state_reg <= WAIT_ACK;
					end
				end
				WAIT_ACK: begin
					ack_o     <= 1'b1;
					rdata_reg <= {16'h0000, rd_word};
					state_reg <= WAIT_IDLE;
				end
			endcase
		end
	end
	assign dat_o = rdata_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			misc_reg  <= `MISC_CTRL_RESET;
			wr_en_reg <= `DMA_EN_RESET;
			rd_en_reg <= `DMA_EN_RESET;
		end else if (do_write) begin
			if (hit_misc) begin
				misc_reg <= (misc_reg & ~misc_wmask) | (dat_i[15:0] & misc_wmask);
			end
			if (hit_wr) begin
				wr_en_reg <= (wr_en_reg & ~lane_mask) | (dat_i[15:0] & lane_mask);
			end
			if (hit_rd) begin
				rd_en_reg <= (rd_en_reg & ~lane_mask) | (dat_i[15:0] & lane_mask);
			end
		end
	end

	// Outputs to the USB core, registered so they never glitch.
	wire osc_selected = misc_reg[`BIT_CLK_SRC_SEL];
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			power_ctrl_o <= '0;
		end else begin
			power_ctrl_o.snooze_request           <= misc_reg[`BIT_SNOOZE_REQ];
			power_ctrl_o.clock_source_select      <= osc_selected;
			power_ctrl_o.pll_enable               <= misc_reg[`BIT_PLL_EN];
			power_ctrl_o.oscillator_output_enable <= misc_reg[`BIT_OSC_OUT_EN]
			                                         & misc_reg[`BIT_CORE_RST_REL];
			power_ctrl_o.bus_power_detected       <= bus_power;
			power_ctrl_o.core_reset_n             <= misc_reg[`BIT_CORE_RST_REL];
			power_ctrl_o.logic_regulator_enable   <= misc_reg[`BIT_LOGIC_REG_EN];
			power_ctrl_o.oscillator_run           <= misc_reg[`BIT_LOGIC_REG_EN]
			                                         & osc_selected;
			power_ctrl_o.phy_regulator_enable     <= misc_reg[`BIT_PHY_REG_EN];
		end
	end

	// Requests flow only once the core is out of reset and bus power is known.
	wire dma_active = bus_power & misc_reg[`BIT_CORE_RST_REL];

	usb_dma_request_gate #(
		.CHANNELS(DMA_CHANNELS)
	) u_write_gate (
		.clk_i           (clk_i),
		.rst_i           (rst_i),
		.enable_i        (wr_en_reg),
		.level_nonzero_i (|fifo_free_space_count_i),
		.active_i        (dma_active),
		.request_o       (dma_req_o.write_req)
	);

	usb_dma_request_gate #(
		.CHANNELS(DMA_CHANNELS)
	) u_read_gate (
		.clk_i           (clk_i),
		.rst_i           (rst_i),
		.enable_i        (rd_en_reg),
		.level_nonzero_i (|fifo_valid_data_count_i),
		.active_i        (dma_active),
		.request_o       (dma_req_o.read_req)
	);
endmodule : usb_power_clock_dma_ctrl
`default_nettype wire

/* core/usb_misc_consts.svh */
`ifndef USB_MISC_CONSTS_SVH
`define USB_MISC_CONSTS_SVH
// Register offsets on the Wishbone bus, in bytes.
`define OFS_MISC_CTRL       4'h0
`define OFS_WR_DMA_EN       4'h4
`define OFS_RD_DMA_EN       4'h8
`define OFS_USB_STATUS      4'hc
// Field positions of the misc control register.
`define BIT_PHY_REG_EN      0
`define BIT_LOGIC_REG_EN    1
`define BIT_CORE_RST_REL    3
`define BIT_BUS_PWR_DET     4
`define BIT_OSC_OUT_EN      5
`define BIT_PLL_EN          6
`define BIT_CLK_SRC_SEL     7
`define BIT_SNOOZE_REQ      8
`define BIT_BUS_WAIT        12
// Writable bits of the misc control register and its reset value.
`define MISC_CTRL_WMASK     16'h11fb
`define MISC_CTRL_RESET     16'h1000
`define DMA_EN_RESET        16'h0000
// Access length in bus cycles for each wait setting.
`define WAIT_LONG_CYCLES    2'h3
`define WAIT_SHORT_CYCLES   2'h1
`endif

/* core/usb_misc_pkg.sv */
`default_nettype none
package usb_misc_pkg;
	typedef struct packed {
		logic phy_regulator_enable;
		logic logic_regulator_enable;
		logic oscillator_run;
		logic oscillator_output_enable;
		logic pll_enable;
		logic clock_source_select;
		logic core_reset_n;
		logic bus_power_detected;
		logic snooze_request;
	} power_ctrl_s;

	typedef struct packed {
		logic [15:0] write_req;
		logic [15:0] read_req;
	} dma_req_s;

	typedef enum logic [1:0] {
		WAIT_IDLE,
		WAIT_COUNT,
		WAIT_ACK
	} bus_state_e;
endpackage : usb_misc_pkg
`default_nettype wire

/* core/usb_dma_request_gate.sv */
`include "usb_misc_consts.svh"
`default_nettype none
module usb_dma_request_gate #(
	parameter int CHANNELS = 16
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Enables and FIFO levels
	input  wire logic [15:0] enable_i,
	input  wire logic        level_nonzero_i,
	input  wire logic        active_i,
	// Requests
	output logic      [15:0] request_o
);
	genvar ch;
	generate
		for (ch = 0; ch < 16; ch++) begin : g_ch
			if (ch < CHANNELS) begin : g_impl
				always_ff @(posedge clk_i) begin
					if (rst_i) begin
						request_o[ch] <= 1'b0;
					end else begin
						request_o[ch] <= enable_i[ch] & level_nonzero_i & active_i;
					end
				end
			end else begin : g_none
				// Missing channels never request, whatever software wrote.
				always_ff @(posedge clk_i) begin
					request_o[ch] <= 1'b0;
				end
			end
		end
	endgenerate
endmodule : usb_dma_request_gate
`default_nettype wire

/* bench/usb_fifo_dma_side.sv */
`default_nettype none
module usb_fifo_dma_side (
	// Settings from the bench
	input  wire logic       clk_i,
	input  wire logic       plug_i,
	input  wire logic [6:0] free_i,
	input  wire logic [6:0] valid_i,
	// Toward the controller
	output logic            mon_o,
	output logic      [6:0] free_o,
	output logic      [6:0] valid_o
);
	// FIFO counters move on the clock, so levels land one cycle late.
	initial {mon_o, free_o, valid_o} = '0;
	always @(posedge clk_i) begin
		mon_o <= plug_i;
		free_o <= free_i;
		valid_o <= valid_i;
	end
endmodule : usb_fifo_dma_side
`default_nettype wire

/* bench/usb_misc_assertions.sv */
`default_nettype none
module usb_misc_assertions (
	// Bus
	input wire logic                 clk_i,
	input wire logic                 rst_i,
	input wire logic                 cyc_i,
	input wire logic                 stb_i,
	input wire logic                 we_i,
	input wire logic [3:0]           adr_i,
	input wire logic [3:0]           sel_i,
	input wire logic [31:0]          dat_i,
	input wire logic [31:0]          dat_o,
	input wire logic                 ack_o,
	// Levels and controls
	input wire logic [6:0]           fifo_free_space_count_i,
	input wire logic [6:0]           fifo_valid_data_count_i,
	input wire usb_misc_pkg::power_ctrl_s power_ctrl_o,
	input wire usb_misc_pkg::dma_req_s    dma_req_o
);
	import usb_misc_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire misc_wr = ack_o && we_i && adr_i == 4'h0;
	a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack too long");
	a_ack_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
		else $error("ack without request");
	a_run_follows: assert property (power_ctrl_o.oscillator_run == (power_ctrl_o
		.logic_regulator_enable && power_ctrl_o.clock_source_select)) else $error("osc run");
	a_osc_gated: assert property (power_ctrl_o.oscillator_output_enable |->
		power_ctrl_o.core_reset_n) else $error("osc out in reset");
	a_wr_level: assert property (|dma_req_o.write_req |-> $past(fifo_free_space_count_i) != 0)
		else $error("write req no space");
	a_rd_level: assert property (|dma_req_o.read_req |-> $past(fifo_valid_data_count_i) != 0)
		else $error("read req no data");
	a_dma_power: assert property (|dma_req_o |-> power_ctrl_o.bus_power_detected ||
		$past(power_ctrl_o.bus_power_detected)) else $error("req without power");
	a_snooze_write: assert property (misc_wr && sel_i[1] |-> ##2
		power_ctrl_o.snooze_request == $past(dat_i[8], 2)) else $error("snooze");
	a_pll_write: assert property (misc_wr && sel_i[0] |-> ##2
		power_ctrl_o.pll_enable == $past(dat_i[6], 2)) else $error("pll");
	a_reserved_zero: assert property (ack_o && !we_i && adr_i == 4'h0 |->
		dat_o[15:13] == 3'h0 && dat_o[11:9] == 3'h0 && !dat_o[2]) else $error("rsvd");
endmodule : usb_misc_assertions
bind usb_power_clock_dma_ctrl usb_misc_assertions u_chk (.clk_i, .rst_i, .cyc_i, .stb_i,
	.we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .fifo_free_space_count_i,
	.fifo_valid_data_count_i, .power_ctrl_o, .dma_req_o);
`default_nettype wire

/* bench/tb.sv */
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import usb_misc_pkg::*;
	logic        clk_i, rst_i, cyc, stb, we, ack_o, plug, mon;
	logic [3:0]  adr;
	logic [31:0] wdat, dat_o;
	logic [6:0]  fs, vs, free, valid;
	logic [15:0] rdat;
	power_ctrl_s pc;
	dma_req_s    dq;
	int          n_errors, n_compared, cycles, n, t_long, t_short;
	usb_fifo_dma_side u_far (.clk_i, .plug_i(plug), .free_i(fs), .valid_i(vs), .mon_o(mon),
		.free_o(free), .valid_o(valid));
	usb_power_clock_dma_ctrl #(.DMA_CHANNELS(12)) DUT (.clk_i, .rst_i, .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'h3), .dat_i(wdat), .dat_o, .ack_o,
		.bus_power_monitor_port_i(mon), .fifo_free_space_count_i(free),
		.fifo_valid_data_count_i(valid), .power_ctrl_o(pc), .dma_req_o(dq));
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d, output int c);
		c = 0;
		@(posedge clk_i);
		{cyc, stb, we} <= {2'b11, w};
		adr <= a;
		wdat <= {16'h0, d};
		do begin
			@(posedge clk_i);
			c++;
		end while (ack_o !== 1'b1);
		rdat = dat_o[15:0];
		{cyc, stb, we} <= 3'b000;
	endtask : bus
	// Outputs are looked at mid-cycle, once the edge's updates have landed.
	task automatic pchk(input logic [8:0] e);
		@(posedge clk_i);
		@(negedge clk_i);
		chk({23'h0, pc}, {23'h0, e});
	endtask : pchk
	task automatic lvl(input logic [6:0] f, input logic [6:0] v, input logic [31:0] e);
		@(posedge clk_i);
		fs <= f;
		vs <= v;
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
		chk(dq, e);
	endtask : lvl
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			print_verdict();
		end
	end
	initial begin
		{cyc, stb, we, plug, adr, wdat, fs, vs} = '0;
		rst_i = 1'b1;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		pchk(9'h000);
		bus(0, 4'h0, 0, n); chk(rdat, 16'h1000);
		bus(1, 4'h0, 16'h1003, n); pchk(9'h180);
		bus(1, 4'h0, 16'h1043, n); pchk(9'h190);
		bus(1, 4'h0, 16'h104b, n); pchk(9'h194);
		bus(0, 4'h4, 0, n); chk(rdat, 16'h0);
		plug <= 1'b1;
		repeat (8) @(posedge clk_i);
		bus(1, 4'h0, 16'h105b, n); pchk(9'h196);
		bus(1, 4'h0, 16'h10fb, n); pchk(9'h1fe);
		bus(1, 4'h0, 16'hffff, n); pchk(9'h1ff);
		bus(0, 4'h0, 0, t_long); chk(rdat, 16'h11fb);
		bus(1, 4'h0, 16'h00fb, n); pchk(9'h1fe);
		bus(0, 4'h0, 0, t_short); chk(32'(t_short + 2), 32'(t_long));
		bus(1, 4'h4, 16'hffff, n);
		bus(1, 4'h8, 16'h8001, n); chk(rdat, 16'h0);
		lvl(7'h01, 7'h00, {16'h0fff, 16'h0000});
		lvl(7'h00, 7'h40, {16'h0000, 16'h0001});
		bus(0, 4'h8, 0, n); chk(rdat, 16'h8001);
		bus(1, 4'h0, 16'h00eb, n); pchk(9'h1fc);
		lvl(7'h7f, 7'h7f, 32'h0);
		bus(0, 4'h8, 0, n); chk(rdat, 16'h0);
		bus(1, 4'h0, 16'h00f3, n); pchk(9'h1da);
		print_verdict();
	end
endmodule : tb
`default_nettype wire
